//--- verilog/pc_stack_indirect.sv
// Function
// R01: The program counter is 13 bits, its low byte is a read/write register and its upper bits are neither readable nor directly writable.
// R02: Every reset clears the whole program counter to zero.
// R03: A write of the low-byte register loads counter bits 12..8 from latch bits 4..0 in the same cycle.
// R04: A call or goto takes counter bits 12..11 from latch bits 4..3.
// R05: A call or goto takes counter bits 10..0 from the instruction's 11-bit operand.
// R06: The return stack has eight 13-bit entries and its pointer is neither readable nor writable.
// R07: A call or an interrupt vectoring pushes the current program counter.
// R08: A return, return-with-literal or return-from-interrupt pops the stack into the counter.
// R09: Pushes and pops leave the high latch unchanged.
// R10: The stack wraps circularly, so the ninth push overwrites the first and the tenth the second.
// R11: No overflow or underflow flag exists and no explicit push or pop command exists.
// R12: The indirect data port holds no data and accesses go to the location held in the file pointer.
// R13: Reading the indirect port through itself returns zero.
// R14: Writing the indirect port through itself writes nothing.
// R15: The indirect address is 9 bits made of the bank bit and the 8-bit file pointer.
// R16: The bank bit is address bit 8 and the file pointer bits 7..0.
module pc_stack_indirect (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Register port
    input  wire logic [7:0]               reg_addr_i,
    input  wire logic [7:0]               reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic      [7:0]               reg_rdata_o,
    // Program flow from execute logic
    input  wire pc_stack_pkg::flow_op_e   flow_op_i,
    input  wire logic [10:0]              jump_target_i,
    // Program counter
    output logic      [12:0]              pc_o,
    // Indirect data memory access
    output pc_stack_pkg::ind_access_s     ind_o,
    input  wire logic [7:0]               ind_rdata_i
);

    logic [12:0] pc_ff;
    logic [12:0] nxt_pc;
    logic [4:0]  pc_high_latch_ff;
    logic [7:0]  file_pointer_reg_ff;
    logic        indirect_bank_bit_ff;
    logic [2:0]  sp_ff;
    logic [2:0]  nxt_sp;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic [12:0] stack_mem [pc_stack_pkg::DEPTH];

    // Address decode
    wire         hit_ind     = (reg_addr_i == pc_stack_pkg::OFS_INDIRECT_PORT);
    wire         hit_pcl     = (reg_addr_i == pc_stack_pkg::OFS_PC_LOW);
    wire         hit_status  = (reg_addr_i == pc_stack_pkg::OFS_STATUS);
    wire         hit_fptr    = (reg_addr_i == pc_stack_pkg::OFS_FILE_POINTER);
    wire         hit_latch   = (reg_addr_i == pc_stack_pkg::OFS_PC_HIGH_LATCH);
    wire         self_ref    = (file_pointer_reg_ff == pc_stack_pkg::OFS_INDIRECT_PORT);
    wire         pcl_write   = reg_wr_i && hit_pcl;
    wire         do_push     = (flow_op_i == pc_stack_pkg::OP_CALL) ||
                               (flow_op_i == pc_stack_pkg::OP_INTERRUPT);     // [R07] [R11]
    wire         do_pop      = (flow_op_i == pc_stack_pkg::OP_RETURN);        // [R08] [R11]
    wire [2:0]   sp_dec      = sp_ff - 3'h1;
    wire [12:0]  pc_step     = pc_ff + 13'h0001;
    wire [12:0]  pc_jump     = {pc_high_latch_ff[pc_stack_pkg::LATCH_PAGE_MSB:
                                                 pc_stack_pkg::LATCH_PAGE_LSB],
                                jump_target_i};                               // [R04] [R05]

    // Next program counter; a low-byte write wins over flow operations
    always_comb begin
        nxt_pc = pc_ff;
        if (pcl_write) begin
            nxt_pc = {pc_high_latch_ff, reg_wdata_i};                         // [R03]
        end else begin
            unique case (flow_op_i)
                pc_stack_pkg::OP_HOLD:      nxt_pc = pc_ff;
                pc_stack_pkg::OP_STEP:      nxt_pc = pc_step;
                pc_stack_pkg::OP_GOTO:      nxt_pc = pc_jump;
                pc_stack_pkg::OP_CALL:      nxt_pc = pc_jump;
                pc_stack_pkg::OP_RETURN:    nxt_pc = stack_mem[sp_dec];       // [R08]
                pc_stack_pkg::OP_INTERRUPT: nxt_pc = pc_stack_pkg::INT_VECTOR;
                default:                    nxt_pc = pc_ff;
            endcase
        end
    end

    // Stack pointer wraps modulo eight
    always_comb begin
        nxt_sp = sp_ff;
        if (!pcl_write && do_push) begin
            nxt_sp = sp_ff + 3'h1;                                            // [R10]
        end else if (!pcl_write && do_pop) begin
            nxt_sp = sp_dec;                                                  // [R10]
        end
    end

    // Read data, one cycle after the strobe
    always_comb begin
        nxt_rdata = pc_stack_pkg::ZERO_BYTE;
        if (reg_rd_i) begin
            if (hit_ind) begin
                nxt_rdata = self_ref ? pc_stack_pkg::ZERO_BYTE : ind_rdata_i; // [R13]
            end else if (hit_pcl) begin
                nxt_rdata = pc_ff[7:0];                                       // [R01]
            end else if (hit_status) begin
                nxt_rdata = {indirect_bank_bit_ff, 7'h00};
            end else if (hit_fptr) begin
                nxt_rdata = file_pointer_reg_ff;
            end else if (hit_latch) begin
                nxt_rdata = {3'h0, pc_high_latch_ff};
            end
        end
    end

    // Indirect access toward data memory
    assign ind_o.addr  = {indirect_bank_bit_ff, file_pointer_reg_ff};         // [R15] [R16]
    assign ind_o.rd    = reg_rd_i && hit_ind && !self_ref;                    // [R12]
    assign ind_o.wr    = reg_wr_i && hit_ind && !self_ref;                    // [R12] [R14]
    assign ind_o.wdata = reg_wdata_i;

    // Program counter and stack pointer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_ff <= pc_stack_pkg::PC_RST;                                    // [R02]
            sp_ff <= pc_stack_pkg::PTR_RST;
        end else begin
            pc_ff <= nxt_pc;                                                  // [R01]
            sp_ff <= nxt_sp;                                                  // [R06]
        end
    end

    // Stack storage, no reset; the push slot is the current pointer
    always_ff @(posedge clk_i) begin
        if (!pcl_write && do_push) begin
            stack_mem[sp_ff] <= pc_ff;                                        // [R07] [R10]
        end
    end

    // Software registers; the latch changes only by its own write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_high_latch_ff     <= pc_stack_pkg::LATCH_RST;
            file_pointer_reg_ff  <= pc_stack_pkg::FILE_PTR_RST;
            indirect_bank_bit_ff <= pc_stack_pkg::BANK_RST;
            rdata_ff             <= pc_stack_pkg::ZERO_BYTE;
        end else begin
            rdata_ff <= nxt_rdata;
            if (reg_wr_i && hit_latch) begin
                pc_high_latch_ff <= reg_wdata_i[4:0];                         // [R09]
            end
            if (reg_wr_i && hit_fptr) begin
                file_pointer_reg_ff <= reg_wdata_i;
            end
            if (reg_wr_i && hit_status) begin
                indirect_bank_bit_ff <= reg_wdata_i[pc_stack_pkg::STATUS_BANK_BIT];
            end
        end
    end

    assign pc_o        = pc_ff;
    assign reg_rdata_o = rdata_ff;

endmodule : pc_stack_indirect

//--- verilog/pc_stack_pkg.sv
package pc_stack_pkg;

    // Widths
    localparam int PC_W    = 13;
    localparam int BYTE_W  = 8;
    localparam int ADDR_W  = 8;
    localparam int IADDR_W = 9;
    localparam int JUMP_W  = 11;
    localparam int DEPTH   = 8;
    localparam int PTR_W   = 3;
    localparam int LATCH_W = 5;

    // Register offsets on the plain register port
    localparam logic [7:0] OFS_INDIRECT_PORT = 8'h00;
    localparam logic [7:0] OFS_PC_LOW        = 8'h02;
    localparam logic [7:0] OFS_STATUS        = 8'h03;
    localparam logic [7:0] OFS_FILE_POINTER  = 8'h04;
    localparam logic [7:0] OFS_PC_HIGH_LATCH = 8'h0a;

    // Field positions
    localparam int STATUS_BANK_BIT = 7;
    localparam int LATCH_PAGE_MSB  = 4;
    localparam int LATCH_PAGE_LSB  = 3;

    // Reset values
    localparam logic [12:0] PC_RST      = 13'h0000;
    localparam logic [4:0]  LATCH_RST   = 5'h00;
    localparam logic [7:0]  FILE_PTR_RST = 8'h00;
    localparam logic        BANK_RST    = 1'b0;
    localparam logic [2:0]  PTR_RST     = 3'h0;
    localparam logic [7:0]  ZERO_BYTE   = 8'h00;

    // Interrupt vector address
    localparam logic [12:0] INT_VECTOR = 13'h0004;

    // Program-flow operations issued by the execute logic
    typedef enum logic [2:0] {
        OP_HOLD,
        OP_STEP,
        OP_GOTO,
        OP_CALL,
        OP_RETURN,
        OP_INTERRUPT
    } flow_op_e;

    // Indirect data access toward data memory
    typedef struct packed {
        logic [8:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } ind_access_s;

endpackage : pc_stack_pkg

//--- dv/pc_stack_indirect_sva.sv
module pc_stack_indirect_sva (
    // Clock and reset
    input wire logic                      clk_i,
    input wire logic                      rst_n_i,
    // Register port
    input wire logic [7:0]                reg_addr_i,
    input wire logic [7:0]                reg_wdata_i,
    input wire logic                      reg_wr_i,
    input wire logic                      reg_rd_i,
    input wire logic [7:0]                reg_rdata_o,
    // Flow and indirect access
    input wire pc_stack_pkg::flow_op_e    flow_op_i,
    input wire logic [10:0]               jump_target_i,
    input wire logic [12:0]               pc_o,
    input wire pc_stack_pkg::ind_access_s ind_o,
    input wire logic [7:0]                ind_rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire low_wr   = reg_wr_i && reg_addr_i == pc_stack_pkg::OFS_PC_LOW;
    wire port_sel = reg_addr_i == pc_stack_pkg::OFS_INDIRECT_PORT;
    wire self_ref = ind_o.addr[7:0] == 8'h00;
    wire jump_op  = flow_op_i == pc_stack_pkg::OP_GOTO || flow_op_i == pc_stack_pkg::OP_CALL;
    a_step_increment: assert property (flow_op_i == pc_stack_pkg::OP_STEP && !low_wr
        |=> pc_o == $past(pc_o) + 13'h1) else $error("pc did not step");
    a_hold_stable: assert property (flow_op_i == pc_stack_pkg::OP_HOLD && !low_wr
        |=> $stable(pc_o)) else $error("pc moved on hold");
    a_jump_operand: assert property (jump_op && !low_wr
        |=> pc_o[10:0] == $past(jump_target_i)) else $error("jump operand lost");
    a_vector_load: assert property (flow_op_i == pc_stack_pkg::OP_INTERRUPT && !low_wr
        |=> pc_o == pc_stack_pkg::INT_VECTOR) else $error("vector not loaded");
    a_low_byte_load: assert property (low_wr
        |=> pc_o[7:0] == $past(reg_wdata_i)) else $error("low byte not loaded");
    a_self_no_access: assert property (self_ref
        |-> !ind_o.rd && !ind_o.wr) else $error("self access reached memory");
    a_port_redirect: assert property (reg_rd_i && port_sel && !self_ref
        |-> ind_o.rd ##1 reg_rdata_o == $past(ind_rdata_i)) else $error("port read lost");
    a_self_read_zero: assert property (reg_rd_i && port_sel && self_ref
        |=> reg_rdata_o == 8'h00) else $error("self read not zero");
    a_write_forward: assert property (reg_wr_i && port_sel && !self_ref
        |-> ind_o.wr && ind_o.wdata == reg_wdata_i) else $error("port write lost");
endmodule : pc_stack_indirect_sva

//--- dv/data_memory_model.sv
module data_memory_model (
    // Clock and access
    input  wire logic                      clk_i,
    input  wire pc_stack_pkg::ind_access_s ind_i,
    output logic      [7:0]                rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [512];
    // Full address picks the byte, an idle bus shows the inverse
    assign rdata_o = ind_i.rd ? mem[ind_i.addr] : ~mem[ind_i.addr];
    always_ff @(posedge clk_i) begin
        if (ind_i.wr) begin
            mem[ind_i.addr] <= ind_i.wdata;
        end
    end
endmodule : data_memory_model

//--- dv/test_pc_stack_indirect.sv
module test_pc_stack_indirect;
    timeunit 1ns;
    timeprecision 1ns;
    logic                      clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic                      rd_d = 1'b0;
    logic [7:0]                reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, ind_rdata_i;
    logic [7:0]                d, f, exp_q [$];
    pc_stack_pkg::flow_op_e    flow_op_i = pc_stack_pkg::OP_HOLD;
    logic [10:0]               jump_target_i = 11'h000, t;
    logic [12:0]               pc_o, pc, stk [8];
    pc_stack_pkg::ind_access_s ind_o;
    logic [4:0]                lat;
    logic [2:0]                sp;
    int                        n_errors = 0, comparisons = 0;
    always #20 clk_i = ~clk_i;
    pc_stack_indirect i_pc_stack_indirect (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .flow_op_i(flow_op_i),
        .jump_target_i(jump_target_i), .pc_o(pc_o), .ind_o(ind_o), .ind_rdata_i(ind_rdata_i));
    data_memory_model i_data_memory_model (.clk_i(clk_i), .ind_i(ind_o), .rdata_o(ind_rdata_i));
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        {reg_rd_i, reg_addr_i} <= {1'b1, a};
        exp_q.push_back(e);
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd
    task automatic op(input pc_stack_pkg::flow_op_e o, input logic [10:0] j);
        @(posedge clk_i);
        {flow_op_i, jump_target_i} <= {o, j};
        @(posedge clk_i);
        flow_op_i <= pc_stack_pkg::OP_HOLD;
        @(negedge clk_i);
        check(pc_o, pc);
    endtask : op
    always @(posedge clk_i) rd_d <= reg_rd_i;
    always @(negedge clk_i) if (rd_d) check({5'h00, reg_rdata_o}, {5'h00, exp_q.pop_front()});
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h44472649));
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        {pc, sp} = 16'h0000;
        @(negedge clk_i);
        check(pc_o, pc);
        wr(pc_stack_pkg::OFS_PC_HIGH_LATCH, 8'h1f);
        wr(pc_stack_pkg::OFS_PC_LOW, 8'hff);
        pc = 13'h1fff;
        @(negedge clk_i);
        check(pc_o, pc);
        rd(pc_stack_pkg::OFS_PC_LOW, 8'hff);
        pc = 13'h0000;
        op(pc_stack_pkg::OP_STEP, 11'h000);
        lat = 5'($urandom());
        wr(pc_stack_pkg::OFS_PC_HIGH_LATCH, {3'h0, lat});
        t = 11'($urandom());
        pc = {lat[4:3], t};
        op(pc_stack_pkg::OP_GOTO, t);
        for (int i = 0; i < 10; i++) begin
            t = 11'($urandom());
            stk[sp] = pc;
            sp++;
            pc = {lat[4:3], t};
            op(pc_stack_pkg::OP_CALL, t);
        end
        for (int i = 0; i < 9; i++) begin
            sp--;
            pc = stk[sp];
            op(pc_stack_pkg::OP_RETURN, 11'h000);
        end
        rd(pc_stack_pkg::OFS_PC_HIGH_LATCH, {3'h0, lat});
        stk[sp] = pc;
        pc = pc_stack_pkg::INT_VECTOR;
        op(pc_stack_pkg::OP_INTERRUPT, 11'h000);
        pc = stk[sp];
        op(pc_stack_pkg::OP_RETURN, 11'h000);
        {d, f} = {8'($urandom()), 8'($urandom()) | 8'h01};
        wr(pc_stack_pkg::OFS_STATUS, 8'h80);
        wr(pc_stack_pkg::OFS_FILE_POINTER, f);
        wr(pc_stack_pkg::OFS_INDIRECT_PORT, d);
        check({4'h0, ind_o.addr}, {5'h01, f});
        wr(pc_stack_pkg::OFS_STATUS, 8'h00);
        wr(pc_stack_pkg::OFS_INDIRECT_PORT, ~d);
        wr(pc_stack_pkg::OFS_STATUS, 8'h80);
        rd(pc_stack_pkg::OFS_INDIRECT_PORT, d);
        rd(pc_stack_pkg::OFS_STATUS, 8'h80);
        wr(pc_stack_pkg::OFS_FILE_POINTER, 8'h00);
        wr(pc_stack_pkg::OFS_INDIRECT_PORT, ~d);
        rd(pc_stack_pkg::OFS_INDIRECT_PORT, 8'h00);
        rd(8'h55, 8'h00);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(negedge clk_i);
        check(pc_o, 13'h0000);
        rst_n_i <= 1'b1;
        print_verdict();
    end
endmodule : test_pc_stack_indirect
bind pc_stack_indirect pc_stack_indirect_sva i_pc_stack_indirect_sva (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .flow_op_i(flow_op_i),
    .jump_target_i(jump_target_i), .pc_o(pc_o), .ind_o(ind_o), .ind_rdata_i(ind_rdata_i));
